// file: shared/slcr_pkg.sv
// Constants and types for the serial link receive configuration block
//
// Function
// - Link control bit 6 clear gives standard link behaviour, set gives vendor transmitter compatibility; resets to 0.
// - With the subclass bit clear (reset) the elastic buffer is released once every enabled lane has started writing.
// - With the subclass bit set the buffer is released only at a release opportunity from the local multiframe counter, shifted by the release delay.
// - With the encoding select bit set the link uses 64b/66b and only then does the sync header mode apply.
// - Sample format bit 1 clear means offset binary, set means two's complement; resets to 1.
// - Scrambler bit 0 enables 8b/10b descrambling when set and disables it when clear; resets to enabled.
// - In 64b/66b modes the scrambler bit is ignored and lane data are always descrambled.
// - The two-bit sync header mode field, reset 0, selects CRC-12 checking of the 32-bit sync word when 0; 1 to 3 are reserved.
// - All command fields of the 64b/66b sync word are ignored.
// - In 8b/10b the frames-per-multiframe field holds K minus one, reset 31 meaning K of 32, and software programs only legal K.
// - In 64b/66b the frames-per-multiframe field is ignored and the effective K is 256 times E over F.
// - Each step of the 6-bit release delay field, reset 0, postpones release opportunities by 4 octets.
// - With the link disabled the receive subsystem and its multiframe counter are held in reset, the PHY is off and SYSREF does not realign.

`default_nettype none

package slcr_pkg;

    // ==========================================================
    // Register indices, byte address is four times the index
    localparam logic [9:0] IDX_LINK_ENABLE   = 10'h100;
    localparam logic [9:0] IDX_LINK_CONTROL  = 10'h103;
    localparam logic [9:0] IDX_SYNC_HEADER   = 10'h104;
    localparam logic [9:0] IDX_FPM           = 10'h105;
    localparam logic [9:0] IDX_RELEASE_DELAY = 10'h106;
    localparam logic [9:0] IDX_LINK_STATUS   = 10'h107;

    // ==========================================================
    // Reset values
    localparam logic [7:0] RST_LINK_ENABLE   = 8'h00;
    localparam logic [7:0] RST_LINK_CONTROL  = 8'h03;
    localparam logic [7:0] RST_SYNC_HEADER   = 8'h00;
    localparam logic [7:0] RST_FPM           = 8'h1F;
    localparam logic [7:0] RST_RELEASE_DELAY = 8'h00;

    // ==========================================================
    // Field positions
    localparam int POS_LINK_ENABLE   = 0;
    localparam int POS_VENDOR_COMPAT = 6;
    localparam int POS_SUBCLASS      = 5;
    localparam int POS_ENCODING      = 4;
    localparam int POS_SAMPLE_FMT    = 1;
    localparam int POS_SCRAMBLER     = 0;
    localparam int POS_EB_ERR        = 7;
    localparam int POS_LINK_UP       = 6;
    localparam int POS_REALIGNED     = 4;
    localparam int POS_ALIGNED       = 3;

    // ==========================================================
    // Field codes and counts
    localparam logic [1:0] SYNHDR_CRC12      = 2'h0;
    localparam int         DLY_WIDTH         = 6;
    localparam int         LANES             = 16;
    localparam int         OCTETS_PER_CYCLE  = 4;
    localparam int         K_64B66B_PER_E    = 256;
    localparam int         PERIOD_WIDTH      = 16;

    // ==========================================================
    // Decoded configuration toward the receive datapath
    typedef struct packed {
        logic vendor_tx_compat_mode;
        logic subclass_one;
        logic link_encoding_select;
        logic sample_twos_complement;
        logic descramble_en;
        logic crc12_check_en;
    } slcr_rx_cfg_t;

endpackage : slcr_pkg

`default_nettype wire

// file: rtl/slcr_sync2.sv
// Two-stage synchroniser for one asynchronous level

`default_nettype none

module slcr_sync2
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic async_in,
    output var  logic sync_out
);

    logic meta_r;

    // ==========================================================
    // Two flops in series
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_r   <= 1'b0;
            sync_out <= 1'b0;
        end
        else
        begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule : slcr_sync2

`default_nettype wire

// file: rtl/slcr_cfg_byte.sv
// One byte-wide read/write configuration register

`default_nettype none

module slcr_cfg_byte
#(
    parameter logic [7:0] RESET_VAL = 8'h00
)
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       wr_en,
    input  wire logic [7:0] wdata,
    output var  logic [7:0] value_r
);

    // ==========================================================
    // Whole byte stored, reserved bits included
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            value_r <= RESET_VAL;
        end
        else if (wr_en)
        begin
            value_r <= wdata;
        end
    end

endmodule : slcr_cfg_byte

`default_nettype wire

// file: rtl/slcr_rx_config.sv
// Link layer configuration registers and elastic buffer release control

`default_nettype none

module slcr_rx_config
(
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output var  logic                  pready,
    output var  logic [31:0]           prdata,
    output var  logic                  pslverr,
    input  wire logic                  sysref_in,
    input  wire logic [15:0]           lane_mask,
    input  wire logic [15:0]           lane_started,
    input  wire logic [4:0]            frame_octets,
    input  wire logic [4:0]            blocks_per_mb,
    input  wire logic                  buffer_fault,
    output var  logic                  rx_subsys_reset_n,
    output var  logic                  phy_enable,
    output var  logic                  buffer_release,
    output var  logic                  lmfc_edge,
    output var  slcr_pkg::slcr_rx_cfg_t rx_cfg
);

    // ==========================================================
    // Bus decode
    logic [9:0]  idx;
    logic        setup_ph;
    logic        access_done;
    logic        wr_lane0;
    logic        hit;
    logic [7:0]  rd_byte;

    logic [7:0]  link_enable_r;
    logic [7:0]  link_control_r;
    logic [7:0]  sync_header_select_r;
    logic [7:0]  fpm_r;
    logic [7:0]  release_delay_r;
    logic        eb_err_r;
    logic        realigned_r;
    logic        aligned_r;

    assign idx         = paddr[11:2];
    assign setup_ph    = psel && !penable;
    assign access_done = psel && penable && pready;
    assign wr_lane0    = access_done && pwrite && pstrb[0];

    always_comb
    begin
        hit     = 1'b1;
        rd_byte = 8'h00;
        case (idx)
            slcr_pkg::IDX_LINK_ENABLE:   rd_byte = link_enable_r;
            slcr_pkg::IDX_LINK_CONTROL:  rd_byte = link_control_r;
            slcr_pkg::IDX_SYNC_HEADER:   rd_byte = sync_header_select_r;
            slcr_pkg::IDX_FPM:           rd_byte = fpm_r;
            slcr_pkg::IDX_RELEASE_DELAY: rd_byte = release_delay_r;
            slcr_pkg::IDX_LINK_STATUS:
            begin
                rd_byte[slcr_pkg::POS_EB_ERR]    = eb_err_r;
                rd_byte[slcr_pkg::POS_LINK_UP]   = buffer_release;
                rd_byte[slcr_pkg::POS_REALIGNED] = realigned_r;
                rd_byte[slcr_pkg::POS_ALIGNED]   = aligned_r;
            end
            default:                     hit     = 1'b0;
        endcase
    end

    // ==========================================================
    // Answer in the first cycle of the access phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (setup_ph)
        begin
            pready  <= 1'b1;
            prdata  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
            pslverr <= !hit;
        end
        else if (access_done)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
    end

    // ==========================================================
    // Configuration registers
    slcr_cfg_byte #(.RESET_VAL(slcr_pkg::RST_LINK_ENABLE)) u_link_enable
    (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (wr_lane0 && idx == slcr_pkg::IDX_LINK_ENABLE),
        .wdata   (pwdata[7:0]),
        .value_r (link_enable_r)
    );

    slcr_cfg_byte #(.RESET_VAL(slcr_pkg::RST_LINK_CONTROL)) u_link_control
    (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (wr_lane0 && idx == slcr_pkg::IDX_LINK_CONTROL),
        .wdata   (pwdata[7:0]),
        .value_r (link_control_r)
    );

    slcr_cfg_byte #(.RESET_VAL(slcr_pkg::RST_SYNC_HEADER)) u_sync_header
    (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (wr_lane0 && idx == slcr_pkg::IDX_SYNC_HEADER),
        .wdata   (pwdata[7:0]),
        .value_r (sync_header_select_r)
    );

    slcr_cfg_byte #(.RESET_VAL(slcr_pkg::RST_FPM)) u_fpm
    (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (wr_lane0 && idx == slcr_pkg::IDX_FPM),
        .wdata   (pwdata[7:0]),
        .value_r (fpm_r)
    );

    slcr_cfg_byte #(.RESET_VAL(slcr_pkg::RST_RELEASE_DELAY)) u_release_delay
    (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (wr_lane0 && idx == slcr_pkg::IDX_RELEASE_DELAY),
        .wdata   (pwdata[7:0]),
        .value_r (release_delay_r)
    );

    // ==========================================================
    // Field extraction
    logic link_en;
    logic subclass_one;
    logic enc_64b66b;
    logic [slcr_pkg::DLY_WIDTH-1:0] rdly;

    assign link_en      = link_enable_r[slcr_pkg::POS_LINK_ENABLE];
    assign subclass_one = link_control_r[slcr_pkg::POS_SUBCLASS];
    assign enc_64b66b   = link_control_r[slcr_pkg::POS_ENCODING];
    assign rdly         = release_delay_r[slcr_pkg::DLY_WIDTH-1:0];

    // ==========================================================
    // Decoded datapath configuration
    slcr_pkg::slcr_rx_cfg_t rx_cfg_nxt;

    always_comb
    begin
        rx_cfg_nxt                        = '0;
        rx_cfg_nxt.vendor_tx_compat_mode  = link_control_r[slcr_pkg::POS_VENDOR_COMPAT];
        rx_cfg_nxt.subclass_one           = subclass_one;
        rx_cfg_nxt.link_encoding_select   = enc_64b66b;
        rx_cfg_nxt.sample_twos_complement = link_control_r[slcr_pkg::POS_SAMPLE_FMT];
        if (enc_64b66b)
        begin
            rx_cfg_nxt.descramble_en = 1'b1;
        end
        else
        begin
            rx_cfg_nxt.descramble_en = link_control_r[slcr_pkg::POS_SCRAMBLER];
        end
        // Only CRC-12 mode checks; reserved codes and sync word commands do nothing
        rx_cfg_nxt.crc12_check_en = enc_64b66b
                                    && sync_header_select_r[1:0] == slcr_pkg::SYNHDR_CRC12;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_cfg <= '0;
        end
        else
        begin
            rx_cfg <= rx_cfg_nxt;
        end
    end

    // ==========================================================
    // Subsystem and PHY hold while the link is disabled
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_subsys_reset_n <= 1'b0;
            phy_enable        <= 1'b0;
        end
        else
        begin
            rx_subsys_reset_n <= link_en;
            phy_enable        <= link_en;
        end
    end

    // ==========================================================
    // Multiframe length in 4-octet steps
    logic [slcr_pkg::PERIOD_WIDTH-1:0] period_words;
    logic [slcr_pkg::PERIOD_WIDTH-1:0] octets_per_mf;

    always_comb
    begin
        if (enc_64b66b)
        begin
            // K is 256*E/F, so K*F is 256*E octets
            octets_per_mf = slcr_pkg::PERIOD_WIDTH'(slcr_pkg::K_64B66B_PER_E * blocks_per_mb);
        end
        else
        begin
            octets_per_mf = (slcr_pkg::PERIOD_WIDTH'(fpm_r) + slcr_pkg::PERIOD_WIDTH'(1))
                            * slcr_pkg::PERIOD_WIDTH'(frame_octets);
        end
        period_words = octets_per_mf / slcr_pkg::PERIOD_WIDTH'(slcr_pkg::OCTETS_PER_CYCLE);
        if (period_words == '0)
        begin
            period_words = slcr_pkg::PERIOD_WIDTH'(1);
        end
    end

    // ==========================================================
    // SYSREF capture and edge
    logic sysref_s;
    logic sysref_d_r;
    logic sysref_rise;

    slcr_sync2 u_sysref_sync
    (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (sysref_in),
        .sync_out (sysref_s)
    );

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sysref_d_r <= 1'b0;
        end
        else
        begin
            sysref_d_r <= sysref_s;
        end
    end

    assign sysref_rise = sysref_s && !sysref_d_r;

    // ==========================================================
    // Local multiframe counter
    logic [slcr_pkg::PERIOD_WIDTH-1:0] lmfc_cnt_r;
    logic [slcr_pkg::PERIOD_WIDTH-1:0] lmfc_cnt_nxt;
    logic                              lmfc_wrap;

    assign lmfc_wrap = lmfc_cnt_r >= period_words - slcr_pkg::PERIOD_WIDTH'(1);

    always_comb
    begin
        if (lmfc_wrap)
        begin
            lmfc_cnt_nxt = '0;
        end
        else
        begin
            lmfc_cnt_nxt = lmfc_cnt_r + slcr_pkg::PERIOD_WIDTH'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lmfc_cnt_r <= '0;
        end
        else if (!link_en)
        begin
            lmfc_cnt_r <= '0;
        end
        else if (sysref_rise)
        begin
            lmfc_cnt_r <= '0;
        end
        else
        begin
            lmfc_cnt_r <= lmfc_cnt_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lmfc_edge <= 1'b0;
        end
        else
        begin
            lmfc_edge <= link_en && lmfc_cnt_r == '0;
        end
    end

    // ==========================================================
    // SYSREF alignment flags
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            aligned_r   <= 1'b0;
            realigned_r <= 1'b0;
        end
        else
        begin
            if (!link_en)
            begin
                aligned_r <= 1'b0;
            end
            else if (sysref_rise)
            begin
                aligned_r <= lmfc_cnt_nxt == '0;
            end
            if (link_en && sysref_rise && lmfc_cnt_nxt != '0)
            begin
                realigned_r <= 1'b1;
            end
            else if (wr_lane0 && idx == slcr_pkg::IDX_LINK_STATUS
                     && pwdata[slcr_pkg::POS_REALIGNED])
            begin
                realigned_r <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Elastic buffer fault flag, set wins over clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            eb_err_r <= 1'b0;
        end
        else if (link_en && buffer_fault)
        begin
            eb_err_r <= 1'b1;
        end
        else if (wr_lane0 && idx == slcr_pkg::IDX_LINK_STATUS
                 && pwdata[slcr_pkg::POS_EB_ERR])
        begin
            eb_err_r <= 1'b0;
        end
    end

    // ==========================================================
    // Elastic buffer release
    logic all_lanes_started;
    logic release_opportunity;
    logic buffer_release_nxt;

    assign all_lanes_started   = lane_mask != '0 && (lane_started & lane_mask) == lane_mask;
    // Opportunity shifted by delay steps of 4 octets
    assign release_opportunity = lmfc_cnt_r == slcr_pkg::PERIOD_WIDTH'(rdly);

    always_comb
    begin
        buffer_release_nxt = buffer_release;
        if (!link_en)
        begin
            buffer_release_nxt = 1'b0;
        end
        else if (!buffer_release && all_lanes_started)
        begin
            if (!subclass_one)
            begin
                buffer_release_nxt = 1'b1;
            end
            else if (release_opportunity)
            begin
                buffer_release_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            buffer_release <= 1'b0;
        end
        else
        begin
            buffer_release <= buffer_release_nxt;
        end
    end

endmodule : slcr_rx_config

`default_nettype wire

// file: verif/slcr_far_tx.sv
// Behavioural transmitter side: lanes begin writing once the PHY is enabled
`default_nettype none

module slcr_far_tx
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        phy_enable,
    input  wire logic        slow,
    output var  logic [15:0] lane_started
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [2:0] gap_r;

    // ========
    // Lane start sequencing, lowest lane first
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lane_started <= 16'h0000;
            gap_r        <= 3'h0;
        end
        else if (!phy_enable)
        begin
            lane_started <= 16'h0000;
        end
        else
        begin
            gap_r <= gap_r + 3'h1;
            if (!slow || gap_r == 3'h0)
                lane_started <= lane_started | (lane_started + 16'h0001);
        end
    end
endmodule : slcr_far_tx

`default_nettype wire

// file: verif/slcr_rx_config_chk.sv
// Port assertions for the link configuration block
`default_nettype none

module slcr_rx_config_chk
(
    input wire logic                   pclk,
    input wire logic                   presetn,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [11:0]            paddr,
    input wire logic [31:0]            pwdata,
    input wire logic [3:0]             pstrb,
    input wire logic                   pready,
    input wire logic                   pslverr,
    input wire logic [15:0]            lane_mask,
    input wire logic [15:0]            lane_started,
    input wire logic                   phy_enable,
    input wire logic                   buffer_release,
    input wire slcr_pkg::slcr_rx_cfg_t rx_cfg
);
    timeunit 1ns;
    timeprecision 1ps;

    // ========
    // Helpers
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic wr_done;
    logic wr_ctl;
    logic wr_len;
    logic all_up;
    assign wr_done = psel && penable && pready && pwrite && pstrb[0];
    assign wr_ctl  = wr_done && (paddr[11:2] == slcr_pkg::IDX_LINK_CONTROL);
    assign wr_len  = wr_done && (paddr[11:2] == slcr_pkg::IDX_LINK_ENABLE);
    assign all_up  = phy_enable && !rx_cfg.subclass_one
                     && ((lane_started & lane_mask) == lane_mask);

    // ========
    // Assertions
    chk_vendor_follow:
        assert property (wr_ctl |-> ##2 rx_cfg.vendor_tx_compat_mode == $past(pwdata[6], 2))
        else $error("vendor mode not taken from write");
    chk_subclass_follow:
        assert property (wr_ctl |-> ##2 rx_cfg.subclass_one == $past(pwdata[5], 2))
        else $error("subclass not taken from write");
    chk_format_follow:
        assert property (wr_ctl |-> ##2 rx_cfg.sample_twos_complement == $past(pwdata[1], 2))
        else $error("sample format not taken from write");
    chk_scr_follow:
        assert property (wr_ctl && !pwdata[4] |-> ##2 rx_cfg.descramble_en == $past(pwdata[0], 2))
        else $error("descramble not taken from write");
    chk_descr_wide:
        assert property (rx_cfg.link_encoding_select |-> rx_cfg.descramble_en)
        else $error("descramble off in wide encoding");
    chk_crc_wide:
        assert property (rx_cfg.crc12_check_en |-> rx_cfg.link_encoding_select)
        else $error("crc check outside wide encoding");
    chk_phy_follow:
        assert property (wr_len |-> ##2 phy_enable == $past(pwdata[0], 2))
        else $error("phy enable not following link enable");
    chk_release_off:
        assert property (!phy_enable ##1 !phy_enable |-> !buffer_release)
        else $error("buffer released with link off");
    chk_release_plain:
        assert property (all_up [*3] |-> buffer_release)
        else $error("buffer not released with all lanes started");

    // ========
    // Covers
    cov_wide: cover property (wr_ctl && pwdata[4]);
    cov_sub1: cover property ($rose(buffer_release) && rx_cfg.subclass_one);
    cov_err: cover property (psel && penable && pready && pslverr);
endmodule : slcr_rx_config_chk

bind slcr_rx_config slcr_rx_config_chk u_chk
(
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
    .lane_mask(lane_mask), .lane_started(lane_started), .phy_enable(phy_enable),
    .buffer_release(buffer_release), .rx_cfg(rx_cfg)
);

`default_nettype wire

// file: verif/tb_top.sv
// Self-checking bench for the link configuration block
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int CTL = slcr_pkg::IDX_LINK_CONTROL;
    localparam int LEN = slcr_pkg::IDX_LINK_ENABLE;

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, sysref_in;
    logic        buffer_fault, rx_subsys_reset_n, phy_enable, buffer_release, lmfc_edge;
    logic        slow, rerr, rel_d;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata, v;
    logic [3:0]  pstrb;
    logic [15:0] lane_mask, lane_started;
    logic [4:0]  frame_octets, blocks_per_mb;
    logic [7:0]  mdl [4];
    int          seed = 2;
    int          fail_count = 0;
    int          checks_done = 0;
    int          cyc, last_e, gap, off, k;
    slcr_pkg::slcr_rx_cfg_t rx_cfg;

    slcr_rx_config uut
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .sysref_in(sysref_in), .lane_mask(lane_mask),
        .lane_started(lane_started), .frame_octets(frame_octets),
        .blocks_per_mb(blocks_per_mb), .buffer_fault(buffer_fault),
        .rx_subsys_reset_n(rx_subsys_reset_n), .phy_enable(phy_enable),
        .buffer_release(buffer_release), .lmfc_edge(lmfc_edge), .rx_cfg(rx_cfg)
    );

    slcr_far_tx u_far
    (
        .pclk(pclk), .presetn(presetn), .phy_enable(phy_enable), .slow(slow),
        .lane_started(lane_started)
    );

    // ========
    // Clock and timing monitor
    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    always @(posedge pclk)
    begin
        cyc   <= cyc + 1;
        rel_d <= buffer_release;
        if (lmfc_edge === 1'b1)
        begin
            gap    <= cyc - last_e;
            last_e <= cyc;
        end
        if (buffer_release === 1'b1 && rel_d !== 1'b1)
            off <= cyc - last_e;
    end

    // ========
    // Tasks and expectations
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input int idx, input logic [31:0] d, input logic [3:0] s);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= 12'(idx * 4);
        pwdata  <= d;
        pstrb   <= s;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        chk(n < 20, 1);
        rdata = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wait_rel;
        int n;
        n = 0;
        while (buffer_release !== 1'b1 && n < 600)
        begin
            @(posedge pclk);
            n++;
        end
        chk(n < 600, 1);
    endtask : wait_rel

    function automatic logic [31:0] exp_cfg(input logic [7:0] c, input logic [7:0] s);
        return {26'h0, c[6], c[5], c[4], c[1], c[4] | c[0], c[4] & (s[1:0] == 2'h0)};
    endfunction : exp_cfg

    function automatic int exp_per(input logic e64, input int kpm, input int f, input int e);
        return e64 ? 64 * e : (kpm + 1) * f / 4;
    endfunction : exp_per

    task automatic complete_run;
        $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run

    // ========
    // Main sequence
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pstrb = 4'h0;
        sysref_in = 1'b0;
        buffer_fault = 1'b0;
        slow = 1'b0;
        lane_mask = 16'hFFFF;
        frame_octets = 5'h04;
        blocks_per_mb = 5'h01;
        mdl = '{8'h03, 8'h00, 8'h1F, 8'h00};
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b0, CTL + i, 32'h0000_0000, 4'h0);
            chk(rdata, {24'h0, mdl[i]});
        end
        chk(rx_cfg, exp_cfg(mdl[0], mdl[1]));
        for (int i = 0; i < 40; i++)
        begin
            k = $unsigned($random(seed)) % 4;
            v = $random(seed);
            apb(1'b1, CTL + k, v, 4'($random(seed)));
            chk(rerr, 0);
            if (pstrb[0])
                mdl[k] = v[7:0];
            apb(1'b0, CTL + k, 32'h0000_0000, 4'h0);
            chk(rdata, {24'h0, mdl[k]});
            chk(rx_cfg, exp_cfg(mdl[0], mdl[1]));
        end
        apb(1'b0, 255, 32'h0000_0000, 4'h0);
        chk(rerr, 1'b1);
        chk(rdata, 32'h0000_0000);
        // Plain release with lanes starting slowly
        lane_mask <= 16'($random(seed)) | 16'h0001;
        slow      <= 1'b1;
        apb(1'b1, CTL, 32'h0000_0003, 4'hF);
        apb(1'b1, LEN, 32'h0000_0001, 4'hF);
        wait_rel();
        chk((lane_started & lane_mask) == lane_mask, 1);
        apb(1'b1, LEN, 32'h0000_0000, 4'hF);
        repeat (3) @(posedge pclk);
        chk({buffer_release, phy_enable, rx_subsys_reset_n}, 0);
        // Counter driven release, narrow then wide encoding
        slow <= 1'b0;
        for (int c = 0; c < 2; c++)
        begin
            apb(1'b1, CTL, c ? 32'h0000_0033 : 32'h0000_0023, 4'hF);
            apb(1'b1, slcr_pkg::IDX_FPM, 32'h0000_0007, 4'hF);
            apb(1'b1, slcr_pkg::IDX_RELEASE_DELAY, c ? 63 : 7, 4'hF);
            apb(1'b1, LEN, 32'h0000_0001, 4'hF);
            wait_rel();
            repeat (140) @(posedge pclk);
            chk(gap, exp_per(c, 7, 4, 1));
            chk(off, c ? 63 : 7);
            {buffer_fault, sysref_in} <= 2'b11;
            apb(1'b0, slcr_pkg::IDX_LINK_STATUS, 32'h0000_0000, 4'h0);
            chk(rdata, 32'h0000_00C0);
            apb(1'b1, LEN, 32'h0000_0000, 4'hF);
        end
        complete_run();
    end

    initial
    begin
        #100_000;
        fail_count++;
        complete_run();
    end
endmodule : tb_top

`default_nettype wire
